// ==== logic/dps_pin_if.v ====
// Purpose: device-side command, power and data logic of a ddr2 pin interface
// Assumes: clk is the true clock; its rising crossing is the command sample point
// Notes:   pins come from controller logic on clk, so they are not synchronised
//
// What this block does
// - sample address and control on rising clock
// - read data beats on both clock levels
// - clock gate high runs clocks, buffers, drivers
// - clock gate low picks power-down or self-refresh
// - power-down entry/exit and refresh entry sampled synchronously
// - self-refresh exit seen from gate level alone
// - input buffers gated per power state
// - select high masks every command
// - command decoded from select and three strobes
// - registered termination enables all x16 lines
// - termination input ignored when disabled in config
// - masked write beats leave stored bytes unchanged
// - mask sampled for each of both beats
// - bank select picks target bank
// - bank select picks config register on load
// - row on activate, column and autoprecharge on access
// - scope bit low one bank, high all
// - load commands store opcode from address
// - device drives edge-aligned strobe on reads
// - low strobe times low byte, high strobe high byte
// - one config bit enables complementary strobes
`timescale 1ns/1ps
`include "dps_regs.vh"

module dps_pin_if #(
   parameter COL_BITS = 4,
   parameter ROW_BITS = 13
) (
   input  wire        clk,
   input  wire        srst,
   // apb slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // command and address pins
   input  wire        cke,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [2:0]  bank_select,
   input  wire [12:0] addr,
   input  wire        termination_ctrl,
   // write data: bit0 of each mask is the rising beat, bit1 the falling beat
   input  wire [15:0] dq_in_rise,
   input  wire [15:0] dq_in_fall,
   input  wire [1:0]  low_byte_mask,
   input  wire [1:0]  high_byte_mask,
   // read data and strobes
   output wire [15:0] dq_out,
   output wire        dq_oe,
   output wire        low_byte_strobe_out,
   output wire        low_byte_strobe_n_out,
   output wire        low_byte_strobe_oe,
   output wire        low_byte_strobe_n_oe,
   output wire        high_byte_strobe_out,
   output wire        high_byte_strobe_n_out,
   output wire        high_byte_strobe_oe,
   output wire        high_byte_strobe_n_oe,
   // power and termination status
   output wire        int_clk_en,
   output wire        clk_buf_en,
   output wire        cmd_buf_en,
   output wire        out_drv_en,
   output wire        term_en
);

   localparam PW_ON  = 2'd0;
   localparam PW_PPD = 2'd1;
   localparam PW_APD = 2'd2;
   localparam PW_SR  = 2'd3;
   localparam DEPTH  = 8 << COL_BITS;
   localparam AW     = 3 + COL_BITS;

   reg [1:0]          pwr_r;
   reg [1:0]          pwr_nxt;
   reg [7:0]          open_r;
   reg [ROW_BITS-1:0] row_r [0:7];
   reg [12:0]         cfg_r [0:3];
   reg [31:0]         mem_r [0:DEPTH-1];
   reg [3:0]          rl_r;
   reg                term_r;
   reg [3:0]          rd_cnt_r;
   reg [31:0]         rd_data_r;
   reg                rd_out_r;
   reg [2:0]          rd_bank_r;
   reg                rd_ap_r;
   reg                wr_pend_r;
   reg [AW-1:0]       wr_idx_r;
   reg [2:0]          wr_bank_r;
   reg                wr_ap_r;
   reg [12:0]         op_lat_r;
   integer            i;

   // internal clock, command buffers and drivers are live only in normal running; the clock buffer stays on except in self-refresh
   wire awake = (pwr_r == PW_ON);
   assign int_clk_en = awake;
   assign out_drv_en = awake;
   assign cmd_buf_en = awake;
   assign clk_buf_en = (pwr_r != PW_SR);

   wire [3:0] cmd    = {cs_n, ras_n, cas_n, we_n};
   wire       cmd_ok = cmd_buf_en & ~cs_n;
   wire       is_act  = cmd_ok & (cmd == `DPS_CMD_ACT);
   wire       is_rd   = cmd_ok & (cmd == `DPS_CMD_RD);
   wire       is_wr   = cmd_ok & (cmd == `DPS_CMD_WR);
   wire       is_pre  = cmd_ok & (cmd == `DPS_CMD_PRE);
   wire       is_ref  = cmd_ok & (cmd == `DPS_CMD_REF);
   wire       is_load = cmd_ok & (cmd == `DPS_CMD_LOAD);

   wire [12:0] ext1       = cfg_r[1];
   // both rtt select bits zero means termination is off altogether
   wire        rtt_off    = ~ext1[`DPS_EXT1_RTT_LO] & ~ext1[`DPS_EXT1_RTT_HI];
   wire        diff_on    = ~ext1[`DPS_EXT1_NDIFF];
   // no open row anywhere decides between precharge and active power-down
   wire        all_idle   = (open_r == 8'h00);
   wire [AW-1:0] acc_idx  = {bank_select, addr[COL_BITS-1:0]};

   // power state: entries and power-down exit use gate sampled on clk;
   // self-refresh exit looks at the gate level only, no command decode
   always @* begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         PW_ON: begin
            if (!cke) begin
               // refresh with a row still open falls back to active power-down
               if (is_ref && all_idle)
                  pwr_nxt = PW_SR;
               else if (!all_idle)
                  pwr_nxt = PW_APD;
               else
                  pwr_nxt = PW_PPD;
            end
         end
         PW_PPD: begin
            // the clock pair stays live, so exit is a sampled gate level
            if (cke)
               pwr_nxt = PW_ON;
         end
         PW_APD: begin
            // open rows are kept; the controller must still respect them
            if (cke)
               pwr_nxt = PW_ON;
         end
         PW_SR: begin
            if (cke)
               pwr_nxt = PW_ON;
         end
         default: pwr_nxt = PW_ON;
      endcase
   end

   always @(posedge clk) begin
      if (srst)
         pwr_r <= PW_ON;
      else
         pwr_r <= pwr_nxt;
   end

   // bank rows and configuration loads, all on the rising clock crossing
   always @(posedge clk) begin
      if (srst) begin
         open_r   <= 8'h00;
         op_lat_r <= 13'h0000;
         for (i = 0; i < 8; i = i + 1)
            row_r[i] <= {ROW_BITS{1'b0}};
         for (i = 0; i < 4; i = i + 1)
            cfg_r[i] <= `DPS_CFG_RST;
      end else begin
         if (is_act) begin
            open_r[bank_select] <= 1'b1;
            row_r[bank_select]  <= addr[ROW_BITS-1:0];
         end
         if (is_pre) begin
            if (addr[`DPS_PRE_ALL_BIT])
               open_r <= 8'h00;
            else
               open_r[bank_select] <= 1'b0;
         end
         // auto-precharge closes the bank once the access beats are done
         if (rd_out_r && rd_ap_r)
            open_r[rd_bank_r] <= 1'b0;
         if (wr_pend_r && wr_ap_r)
            open_r[wr_bank_r] <= 1'b0;
         if (is_load) begin
            op_lat_r <= addr;
            if (bank_select == `DPS_BA_MAIN)
               cfg_r[0] <= addr;
            else if (bank_select == `DPS_BA_EXT1)
               cfg_r[1] <= addr;
            else if (bank_select == `DPS_BA_EXT2)
               cfg_r[2] <= addr;
            else if (bank_select == `DPS_BA_EXT3)
               cfg_r[3] <= addr;
         end
      end
   end

   // termination is registered, and gated off when the config disables it;
   // in self-refresh its receiver is off, so the last request is held
   reg term_nxt;
   always @* begin
      if (rtt_off)
         term_nxt = 1'b0;
      else if (clk_buf_en)
         term_nxt = termination_ctrl;
      else
         term_nxt = term_r;
   end

   always @(posedge clk) begin
      if (srst)
         term_r <= 1'b0;
      else
         term_r <= term_nxt;
   end
   // one enable covers all sixteen dq, both strobe pairs and both masks
   assign term_en = term_r & ~rtt_off;

   // write beats arrive one cycle after the write command
   always @(posedge clk) begin
      if (srst) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= {AW{1'b0}};
         wr_bank_r <= 3'h0;
         wr_ap_r   <= 1'b0;
      end else begin
         wr_pend_r <= is_wr;
         if (is_wr) begin
            wr_idx_r  <= acc_idx;
            wr_bank_r <= bank_select;
            wr_ap_r   <= addr[`DPS_PRE_ALL_BIT];
         end
      end
   end

   // data and mask receivers are off whenever the command buffers are off;
   // an off mask reads as masked so a stray beat can never reach the array
   wire [15:0] rise_in = dq_in_rise & {16{cmd_buf_en}};
   wire [15:0] fall_in = dq_in_fall & {16{cmd_buf_en}};
   wire [1:0]  lo_mask = low_byte_mask | {2{~cmd_buf_en}};
   wire [1:0]  hi_mask = high_byte_mask | {2{~cmd_buf_en}};

   // per-byte merge: a masked beat byte keeps the stored value
   wire [31:0] wr_beats = {fall_in, rise_in};
   wire [3:0]  wr_keep  = {hi_mask[1], lo_mask[1], hi_mask[0], lo_mask[0]};
   wire [31:0] wr_old   = mem_r[wr_idx_r];
   wire [31:0] wmerge;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         // lanes 0 and 1 carry the rising beat, lanes 2 and 3 the falling one
         assign wmerge[8*g+7:8*g] = wr_keep[g] ? wr_old[8*g+7:8*g]
                                               : wr_beats[8*g+7:8*g];
      end
   endgenerate

   // the array has no reset: contents are undefined until written
   always @(posedge clk) begin
      if (wr_pend_r)
         mem_r[wr_idx_r] <= wmerge;
   end

   // read: capture on command, present after the programmed latency;
   // one outstanding read only, a new read restarts the countdown
   always @(posedge clk) begin
      if (srst) begin
         rd_cnt_r  <= 4'h0;
         rd_data_r <= 32'h0000_0000;
         rd_out_r  <= 1'b0;
         rd_bank_r <= 3'h0;
         rd_ap_r   <= 1'b0;
      end else begin
         rd_out_r <= 1'b0;
         if (is_rd) begin
            rd_data_r <= mem_r[acc_idx];
            rd_bank_r <= bank_select;
            rd_ap_r   <= addr[`DPS_PRE_ALL_BIT];
            if (rl_r == 4'h0)
               rd_out_r <= 1'b1;
            else
               rd_cnt_r <= rl_r;
         end else if (rd_cnt_r != 4'h0) begin
            rd_cnt_r <= rd_cnt_r - 4'h1;
            if (rd_cnt_r == 4'h1)
               rd_out_r <= 1'b1;
         end
      end
   end

   // clk high carries the rising beat, clk low the falling beat
   wire drive = rd_out_r & out_drv_en;
   assign dq_out = clk ? rd_data_r[15:0] : rd_data_r[31:16];
   assign dq_oe  = drive;
   // strobe edges line up with the beat changes
   assign low_byte_strobe_out    = clk;
   assign high_byte_strobe_out   = clk;
   assign low_byte_strobe_n_out  = ~clk;
   assign high_byte_strobe_n_out = ~clk;
   assign low_byte_strobe_oe     = drive;
   assign high_byte_strobe_oe    = drive;
   assign low_byte_strobe_n_oe   = drive & diff_on;
   assign high_byte_strobe_n_oe  = drive & diff_on;

   // apb slave: zero wait states, every access completes in its access phase
   assign pready  = 1'b1;
   // unmapped offsets answer with an error and drop any write data
   reg    decoded;
   always @* begin
      if (paddr == `DPS_OFF_CTRL)
         decoded = 1'b1;
      else if (paddr == `DPS_OFF_STATUS)
         decoded = 1'b1;
      else if (paddr == `DPS_OFF_CFG0)
         decoded = 1'b1;
      else if (paddr == `DPS_OFF_CFG1)
         decoded = 1'b1;
      else if (paddr == `DPS_OFF_CFG2)
         decoded = 1'b1;
      else if (paddr == `DPS_OFF_CFG3)
         decoded = 1'b1;
      else
         decoded = 1'b0;
   end
   assign pslverr = psel & penable & ~decoded;
   wire   apb_wr  = psel & penable & pwrite;

   // the ctrl reset word is 32 bits wide; only the latency field is stored
   wire [31:0] ctrl_rst = `DPS_CTRL_RST;

   always @(posedge clk) begin
      if (srst)
         rl_r <= ctrl_rst[`DPS_CTRL_RL_MSB:`DPS_CTRL_RL_LSB];
      else if (apb_wr && paddr == `DPS_OFF_CTRL)
         rl_r <= pwdata[`DPS_CTRL_RL_MSB:`DPS_CTRL_RL_LSB];
   end

   // status fields, packed below in the register's bit order
   wire [1:0]  st_pwr   = pwr_r;
   wire [7:0]  st_open  = open_r;
   wire        st_term  = term_en;
   wire        st_diff  = diff_on;
   wire [31:0] status_w = {14'h0000, st_diff, st_term, st_open, 6'h00, st_pwr};

   always @* begin
      if (paddr == `DPS_OFF_CTRL)
         prdata = {28'h000_0000, rl_r};
      else if (paddr == `DPS_OFF_STATUS)
         prdata = status_w;
      else if (paddr == `DPS_OFF_CFG0)
         prdata = {19'h0_0000, cfg_r[0]};
      else if (paddr == `DPS_OFF_CFG1)
         prdata = {19'h0_0000, cfg_r[1]};
      else if (paddr == `DPS_OFF_CFG2)
         prdata = {19'h0_0000, cfg_r[2]};
      else if (paddr == `DPS_OFF_CFG3)
         prdata = {19'h0_0000, cfg_r[3]};
      else
         prdata = 32'h0000_0000;
   end

endmodule // dps_pin_if

// ==== include/dps_regs.vh ====
// Purpose: shared constants for the ddr pin interface block
// Assumes: included by bare name from the logic file
// Notes:   offsets are byte addresses on a 32-bit apb
`ifndef DPS_REGS_VH
`define DPS_REGS_VH
// apb register byte offsets
`define DPS_OFF_CTRL        8'h00
`define DPS_OFF_STATUS      8'h04
`define DPS_OFF_CFG0        8'h08
`define DPS_OFF_CFG1        8'h0C
`define DPS_OFF_CFG2        8'h10
`define DPS_OFF_CFG3        8'h14
// ctrl fields and reset value
`define DPS_CTRL_RL_LSB     0
`define DPS_CTRL_RL_MSB     3
`define DPS_CTRL_RST        32'h0000_0003
// status fields
`define DPS_ST_PWR_LSB      0
`define DPS_ST_PWR_MSB      1
`define DPS_ST_OPEN_LSB     8
`define DPS_ST_OPEN_MSB     15
`define DPS_ST_TERM_BIT     16
`define DPS_ST_DIFF_BIT     17
// command codes {cs_n, ras_n, cas_n, we_n}
`define DPS_CMD_ACT         4'h3
`define DPS_CMD_RD          4'h5
`define DPS_CMD_WR          4'h4
`define DPS_CMD_PRE         4'h2
`define DPS_CMD_REF         4'h1
`define DPS_CMD_LOAD        4'h0
// bank codes selecting configuration registers
`define DPS_BA_MAIN         3'h0
`define DPS_BA_EXT1         3'h1
`define DPS_BA_EXT2         3'h2
`define DPS_BA_EXT3         3'h3
// ext_config_reg_one bit positions
`define DPS_EXT1_RTT_LO     2
`define DPS_EXT1_RTT_HI     6
`define DPS_EXT1_NDIFF      10
// precharge_scope_bit position in the address
`define DPS_PRE_ALL_BIT     10
// config reset value
`define DPS_CFG_RST         13'h0000
`endif

// ==== dv/dps_pin_if_props.sv ====
// Purpose: port-level checks of the ddr pin interface
// Assumes: read latency stays at its reset value of 3
// Notes:   bound to every dps_pin_if instance
`timescale 1ns/1ps
module dps_pin_if_props (
   input wire clk,
   input wire srst,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire termination_ctrl,
   input wire dq_oe,
   input wire low_byte_strobe_oe,
   input wire high_byte_strobe_oe,
   input wire low_byte_strobe_n_oe,
   input wire high_byte_strobe_n_oe,
   input wire int_clk_en,
   input wire clk_buf_en,
   input wire cmd_buf_en,
   input wire out_drv_en,
   input wire term_en
);
   wire rd_cmd  = cmd_buf_en && !cs_n && ras_n && !cas_n && we_n;
   wire ref_cmd = cmd_buf_en && !cs_n && !ras_n && !cas_n && we_n;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_read_taken;
      rd_cmd;
   endsequence
   sequence s_beat_out;
      ##4 dq_oe ##1 !dq_oe;
   endsequence
   chk_read_latency: assert property (s_read_taken |-> s_beat_out)
      else $error("read beats not on time");
   chk_strobe_oe: assert property (low_byte_strobe_oe == dq_oe && high_byte_strobe_oe == dq_oe)
      else $error("strobe drive differs from data drive");
   chk_diff_strobe: assert property (low_byte_strobe_n_oe |-> dq_oe && high_byte_strobe_n_oe)
      else $error("complementary strobe driven alone");
   chk_gate_outputs: assert property (int_clk_en == cmd_buf_en && out_drv_en == cmd_buf_en)
      else $error("clocks or drivers disagree with power state");
   chk_sr_buffers: assert property (!clk_buf_en |-> !cmd_buf_en)
      else $error("command buffers on in self-refresh");
   chk_pd_entry: assert property (cmd_buf_en && !cke && !ref_cmd |=> !cmd_buf_en && clk_buf_en)
      else $error("power-down not entered");
   chk_sr_entry: assert property (ref_cmd && !cke |=> !cmd_buf_en)
      else $error("low-power state not entered on refresh");
   chk_gate_exit: assert property (!cmd_buf_en && cke |=> cmd_buf_en)
      else $error("low-power exit missed");
   chk_term_follow: assert property ($rose(term_en) |-> $past(termination_ctrl))
      else $error("termination on without request");
endmodule // dps_pin_if_props

bind dps_pin_if dps_pin_if_props i_props (.clk, .srst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
   .termination_ctrl, .dq_oe, .low_byte_strobe_oe, .high_byte_strobe_oe, .low_byte_strobe_n_oe,
   .high_byte_strobe_n_oe, .int_clk_en, .clk_buf_en, .cmd_buf_en, .out_drv_en, .term_en);

// ==== dv/dps_ctrl_model.sv ====
// Purpose: memory controller model driving command, address and write beats
// Assumes: all changes land by non-blocking assignment just after a rising edge
// Notes:   released address, bank and data lines show the inverse of their last value; strobes and masks return high
`timescale 1ns/1ps
module dps_ctrl_model (
   input  wire         clk,
   output logic        cke = 1'b1,
   output logic        cs_n = 1'b1,
   output logic        ras_n = 1'b1,
   output logic        cas_n = 1'b1,
   output logic        we_n = 1'b1,
   output logic [2:0]  bank_select = 3'h0,
   output logic [12:0] addr = 13'h0000,
   output logic [15:0] dq_in_rise = 16'h0000,
   output logic [15:0] dq_in_fall = 16'h0000,
   output logic [1:0]  low_byte_mask = 2'h3,
   output logic [1:0]  high_byte_mask = 2'h3
);
   // code is {select, row, column, write}; g is the clock gate held from this edge on
   task automatic cmd(input logic [3:0] code, input logic [2:0] ba, input logic [12:0] a,
                      input logic g);
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= code;
      bank_select <= ba;
      addr <= a;
      cke <= g;
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hf;
      bank_select <= ~ba;
      addr <= ~a;
   endtask
   task automatic wr(input logic [2:0] ba, input logic [3:0] col, input logic [15:0] r, f,
                     input logic [1:0] lm, hm);
      cmd(4'h4, ba, {9'h000, col}, 1'b1);
      dq_in_rise <= r;
      dq_in_fall <= f;
      low_byte_mask <= lm;
      high_byte_mask <= hm;
      @(posedge clk);
      dq_in_rise <= ~r;
      dq_in_fall <= ~f;
      low_byte_mask <= 2'h3;
      high_byte_mask <= 2'h3;
   endtask
endmodule // dps_ctrl_model

// ==== dv/test_dps_pin_if.sv ====
// Purpose: self-checking bench for the ddr pin interface
// Assumes: read latency left at 3; registers reached over apb
// Notes:   stops on a cycle ceiling if a handshake hangs
`timescale 1ns/1ps
`include "dps_regs.vh"
module test_dps_pin_if;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, termination_ctrl = 0, err_v;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, rd_v;
   wire [31:0] prdata;
   wire [15:0] dq_out, dq_in_rise, dq_in_fall;
   wire [12:0] addr;
   wire [2:0] bank_select;
   wire [1:0] low_byte_mask, high_byte_mask;
   wire pready, pslverr, cke, cs_n, ras_n, cas_n, we_n, dq_oe, clk_buf_en, cmd_buf_en, term_en;
   int n_fail = 0, check_count = 0, cyc = 0;
   always #25 clk = ~clk;
   dps_ctrl_model i_ctl (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .addr,
      .dq_in_rise, .dq_in_fall, .low_byte_mask, .high_byte_mask);
   dps_pin_if i_dut (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .addr, .termination_ctrl,
      .dq_in_rise, .dq_in_fall, .low_byte_mask, .high_byte_mask, .dq_out, .dq_oe,
      .low_byte_strobe_out(), .low_byte_strobe_n_out(), .low_byte_strobe_oe(),
      .low_byte_strobe_n_oe(), .high_byte_strobe_out(), .high_byte_strobe_n_out(),
      .high_byte_strobe_oe(), .high_byte_strobe_n_oe(), .int_clk_en(), .clk_buf_en,
      .cmd_buf_en, .out_drv_en(), .term_en);
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic st(input logic [31:0] e);
      apb(0, `DPS_OFF_STATUS, 32'h0000_0000);
      chk("status", e, rd_v);
   endtask
   // data returns in the cycle after the third edge past the command edge
   task automatic rd(input logic [2:0] ba, input logic [3:0] col, input logic [15:0] r, f);
      i_ctl.cmd(4'h5, ba, {9'h000, col}, 1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk("dq_oe", 32'h0000_0001, {31'h0, dq_oe});
      chk("rise beat", {16'h0000, r}, {16'h0000, dq_out});
      #25;
      chk("fall beat", {16'h0000, f}, {16'h0000, dq_out});
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 0;
      apb(0, `DPS_OFF_CTRL, 32'h0000_0000);
      chk("ctrl", `DPS_CTRL_RST, rd_v);
      st(32'h0002_0000);
      apb(1, `DPS_OFF_CTRL, 32'h0000_0003);
      apb(0, 8'h18, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, {rd_v[30:0], err_v});
      for (int i = 0; i < 4; i++) i_ctl.cmd(4'h0, 3'(i), 13'h0100 + 13'(i * 8'h45), 1'b1);
      for (int i = 0; i < 4; i++) begin
         apb(0, `DPS_OFF_CFG0 + 8'(4 * i), 32'h0000_0000);
         chk("cfg", 32'h0000_0100 + 32'(i * 8'h45), rd_v);
      end
      termination_ctrl <= 1;
      st(32'h0003_0000);
      i_ctl.cmd(4'h0, `DPS_BA_EXT1, 13'h0400, 1'b1);
      st(32'h0000_0000);
      i_ctl.cmd(4'h3, 3'h2, 13'h0011, 1'b1);
      i_ctl.cmd(4'h3, 3'h5, 13'h0022, 1'b1);
      i_ctl.cmd(4'hb, 3'h7, 13'h0033, 1'b1);
      st(32'h0000_2400);
      i_ctl.wr(3'h2, 4'h5, 16'h1234, 16'habcd, 2'h0, 2'h0);
      i_ctl.wr(3'h5, 4'h5, 16'h5555, 16'h6666, 2'h0, 2'h0);
      rd(3'h2, 4'h5, 16'h1234, 16'habcd);
      rd(3'h5, 4'h5, 16'h5555, 16'h6666);
      i_ctl.wr(3'h2, 4'h5, 16'hffff, 16'hffff, 2'h1, 2'h2);
      rd(3'h2, 4'h5, 16'hff34, 16'habff);
      i_ctl.cmd(4'h2, 3'h2, 13'h0000, 1'b1);
      st(32'h0000_2000);
      i_ctl.cmd(4'h2, 3'h0, 13'h0400, 1'b1);
      st(32'h0000_0000);
      i_ctl.cmd(4'h3, 3'h3, 13'h0000, 1'b1);
      i_ctl.cmd(4'hf, 3'h0, 13'h0000, 1'b0);
      st(32'h0000_0802);
      chk("buffers", 32'h0000_0001, {30'h0, cmd_buf_en, clk_buf_en});
      i_ctl.cmd(4'hf, 3'h0, 13'h0000, 1'b1);
      i_ctl.cmd(4'h2, 3'h0, 13'h0400, 1'b1);
      i_ctl.cmd(4'hf, 3'h0, 13'h0000, 1'b0);
      st(32'h0000_0001);
      i_ctl.cmd(4'hf, 3'h0, 13'h0000, 1'b1);
      i_ctl.cmd(4'h1, 3'h0, 13'h0000, 1'b0);
      st(32'h0000_0003);
      chk("sr buffers", 32'h0000_0000, {30'h0, cmd_buf_en, clk_buf_en});
      i_ctl.cmd(4'hf, 3'h0, 13'h0000, 1'b1);
      st(32'h0000_0000);
      tally_and_finish();
   end
endmodule // test_dps_pin_if
